//--- sleep_mode_params.svh
// Offsets, field positions and reset values of the sleep mode controller
`ifndef SLEEP_MODE_PARAMS_SVH
`define SLEEP_MODE_PARAMS_SVH
`define SM_ADDR_W 4
`define SM_OFF_CTRL 4'h0
`define SM_OFF_MODE 4'h4
`define SM_OFF_MSTBY 4'h8
`define SM_OFF_IRQ 4'hc
`define SM_BIT_TMR 0
`define SM_BIT_LS_SEL 1
`define SM_BIT_MS 2
`define SM_BIT_DT 3
`define SM_BIT_SBY 4
`define SM_CTRL_RST 5'h00
`define SM_MSTBY_RST 8'h00
`define SM_NUM_PERIPH 8
`endif

//--- sleep_mode_pkg.sv
// Types of the sleep mode controller
package sleep_mode_pkg;
  typedef enum logic [6:0] {
    MODE_HIGH_SPEED = 7'h01,
    MODE_MEDIUM_SPEED = 7'h02,
    MODE_SUBACTIVE = 7'h04,
    MODE_SLEEP = 7'h08,
    MODE_STANDBY = 7'h10,
    MODE_WATCH = 7'h20,
    MODE_SUBSLEEP = 7'h40
  } mode_t;
endpackage

//--- sleep_mode_transition_control.sv
// Operating mode sequencer entered on a sleep instruction, with module standby
//
// Functional notes
// RULE_01: With direct transition off, sleep in active mode enters standby, watch or sleep.
// RULE_02: With direct transition off, sleep in subactive mode enters watch or subsleep.
// RULE_03: With direct transition on, high-speed goes to medium-speed or subactive per bits.
// RULE_04: With direct transition on, medium-speed goes to high-speed or subactive per bits.
// RULE_05: With direct transition on, subactive goes to high- or medium-speed per bits.
// RULE_06: Leaving standby, watch or sleep resumes at the speed the medium flag selects.
// RULE_07: A peripheral put in module standby keeps its pending interrupt asserted.
// RULE_08: Software sets module standby only while interrupts are prohibited.
// RULE_09: After reset the core is in high-speed active with both flags cleared.
`timescale 1ns/1ps
`include "sleep_mode_params.svh"

module sleep_mode_transition_control (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [`SM_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic sleep_exec_i,
  input wire logic wake_event_i,
  input wire logic [`SM_NUM_PERIPH-1:0] periph_irq_i,
  output logic [6:0] mode_o,
  output logic [`SM_NUM_PERIPH-1:0] periph_irq_o,
  output logic [`SM_NUM_PERIPH-1:0] periph_stop_o
);

  logic rst_meta;
  logic rst_sync;
  logic [1:0] sleep_sync;
  logic [1:0] wake_sync;
  logic sleep_prev;
  logic sleep_pulse;
  logic [`SM_NUM_PERIPH-1:0] irq_meta;
  logic [`SM_NUM_PERIPH-1:0] irq_sync;
  logic [4:0] ctrl;
  logic [`SM_NUM_PERIPH-1:0] mstby;
  sleep_mode_pkg::mode_t mode;
  sleep_mode_pkg::mode_t next_mode;
  logic acc_pend;
  logic dt;
  logic ms;
  logic sby;
  logic ls;
  logic tmr;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pin input synchronisers
  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      sleep_sync <= 2'h0;
      wake_sync <= 2'h0;
      sleep_prev <= 1'b0;
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_exec_i};
      wake_sync <= {wake_sync[0], wake_event_i};
      sleep_prev <= sleep_sync[1];
      irq_meta <= periph_irq_i;
      irq_sync <= irq_meta;
    end
  end

  assign sleep_pulse = sleep_sync[1] & ~sleep_prev;
  assign dt = ctrl[`SM_BIT_DT];
  assign ms = ctrl[`SM_BIT_MS];
  assign sby = ctrl[`SM_BIT_SBY];
  assign ls = ctrl[`SM_BIT_LS_SEL];
  assign tmr = ctrl[`SM_BIT_TMR];

  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      acc_pend <= 1'b0;
      waitrequest_o <= 1'b1;
    end else if ((read_i || write_i) && !acc_pend) begin
      acc_pend <= 1'b1;
      waitrequest_o <= 1'b0;
    end else begin
      acc_pend <= 1'b0;
      waitrequest_o <= 1'b1;
    end
  end

  // Control and module standby registers
  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      // RULE_09: flags cleared
      ctrl <= `SM_CTRL_RST;
      mstby <= `SM_MSTBY_RST;
    end else if (write_i && acc_pend) begin
      if (address_i == `SM_OFF_CTRL) begin
        ctrl <= writedata_i[4:0];
      end else if (address_i == `SM_OFF_MSTBY) begin
        mstby <= writedata_i[`SM_NUM_PERIPH-1:0];
      end
    end
  end

  // Read data mux, unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      readdata_o <= 32'h0;
    end else if (read_i && !acc_pend) begin
      if (address_i == `SM_OFF_CTRL) begin
        readdata_o <= {27'h0, ctrl};
      end else if (address_i == `SM_OFF_MODE) begin
        readdata_o <= {25'h0, mode};
      end else if (address_i == `SM_OFF_MSTBY) begin
        readdata_o <= {24'h0, mstby};
      end else if (address_i == `SM_OFF_IRQ) begin
        readdata_o <= {24'h0, irq_sync};
      end else begin
        readdata_o <= 32'h0;
      end
    end
  end

  // Next mode on sleep or wake
  always_comb begin
    next_mode = mode;
    case (mode)
      sleep_mode_pkg::MODE_HIGH_SPEED, sleep_mode_pkg::MODE_MEDIUM_SPEED: begin
        if (sleep_pulse) begin
          if (!dt) begin
            // RULE_01: low-power entry from active
            if (!sby) begin
              next_mode = sleep_mode_pkg::MODE_SLEEP;
            end else if (tmr) begin
              next_mode = sleep_mode_pkg::MODE_WATCH;
            end else begin
              next_mode = sleep_mode_pkg::MODE_STANDBY;
            end
          end else if (sby && tmr && ls) begin
            // RULE_03: to subactive
            // RULE_04: to subactive
            next_mode = sleep_mode_pkg::MODE_SUBACTIVE;
          end else if (!sby && !ls && mode == sleep_mode_pkg::MODE_HIGH_SPEED && ms) begin
            // RULE_03: to medium speed
            next_mode = sleep_mode_pkg::MODE_MEDIUM_SPEED;
          end else if (!sby && !ls && mode == sleep_mode_pkg::MODE_MEDIUM_SPEED && !ms) begin
            // RULE_04: to high speed
            next_mode = sleep_mode_pkg::MODE_HIGH_SPEED;
          end
        end
      end
      sleep_mode_pkg::MODE_SUBACTIVE: begin
        if (sleep_pulse) begin
          if (!dt) begin
            // RULE_02: watch or subsleep
            next_mode = (sby && tmr) ? sleep_mode_pkg::MODE_WATCH
                                     : sleep_mode_pkg::MODE_SUBSLEEP;
          end else if (sby && tmr && !ls) begin
            // RULE_05: back to active speed
            next_mode = ms ? sleep_mode_pkg::MODE_MEDIUM_SPEED
                           : sleep_mode_pkg::MODE_HIGH_SPEED;
          end
        end
      end
      sleep_mode_pkg::MODE_SUBSLEEP: begin
        if (wake_sync[1]) begin
          next_mode = sleep_mode_pkg::MODE_SUBACTIVE;
        end
      end
      default: begin
        // RULE_06: resume speed from flag
        if (wake_sync[1]) begin
          next_mode = ms ? sleep_mode_pkg::MODE_MEDIUM_SPEED
                         : sleep_mode_pkg::MODE_HIGH_SPEED;
        end
      end
    endcase
  end

  // Mode register
  always_ff @(posedge clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      // RULE_09: start at high speed
      mode <= sleep_mode_pkg::MODE_HIGH_SPEED;
    end else begin
      mode <= next_mode;
    end
  end

  assign mode_o = mode;

  // Per peripheral stop and frozen request
  genvar gi;
  generate
    for (gi = 0; gi < `SM_NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
          periph_stop_o[gi] <= 1'b0;
          periph_irq_o[gi] <= 1'b0;
        end else begin
          periph_stop_o[gi] <= mstby[gi];
          // RULE_07: halted module holds its request
          if (!mstby[gi]) begin
            periph_irq_o[gi] <= irq_sync[gi];
          end
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_sync);

  active_to_lp_a: assert property ( // RULE_01
    (mode == sleep_mode_pkg::MODE_HIGH_SPEED && sleep_pulse && !dt)
      |=> (mode inside {sleep_mode_pkg::MODE_SLEEP, sleep_mode_pkg::MODE_WATCH,
                        sleep_mode_pkg::MODE_STANDBY}))
    else $error("active sleep did not enter low power");
  sub_to_lp_a: assert property ( // RULE_02
    (mode == sleep_mode_pkg::MODE_SUBACTIVE && sleep_pulse && !dt)
      |=> (mode inside {sleep_mode_pkg::MODE_WATCH, sleep_mode_pkg::MODE_SUBSLEEP}))
    else $error("subactive sleep wrong target");
  hs_direct_a: assert property ( // RULE_03
    (mode == sleep_mode_pkg::MODE_HIGH_SPEED && sleep_pulse && dt && !sby && ms && !ls)
      |=> mode == sleep_mode_pkg::MODE_MEDIUM_SPEED)
    else $error("high to medium direct failed");
  ms_direct_a: assert property ( // RULE_04
    (mode == sleep_mode_pkg::MODE_MEDIUM_SPEED && sleep_pulse && dt && sby && tmr && ls)
      |=> mode == sleep_mode_pkg::MODE_SUBACTIVE)
    else $error("medium to subactive direct failed");
  sub_direct_a: assert property ( // RULE_05
    (mode == sleep_mode_pkg::MODE_SUBACTIVE && sleep_pulse && dt && sby && tmr && !ls && !ms)
      |=> mode == sleep_mode_pkg::MODE_HIGH_SPEED)
    else $error("subactive to high direct failed");
  wake_speed_a: assert property ( // RULE_06
    (mode == sleep_mode_pkg::MODE_STANDBY && wake_sync[1] && ms)
      |=> mode_o == sleep_mode_pkg::MODE_MEDIUM_SPEED)
    else $error("wake speed wrong");
  irq_hold_a: assert property ( // RULE_07
    (mstby[0] && $past(mstby[0])) |=> $stable(periph_irq_o[0]))
    else $error("halted request changed");
  reset_state_a: assert property ( // RULE_09
    $rose(rst_sync) |-> (mode == sleep_mode_pkg::MODE_HIGH_SPEED && ctrl == 5'h00))
    else $error("reset state wrong");
  reset_outputs_a: assert property ( // RULE_09
    $rose(rst_sync) |-> (periph_stop_o == '0 && periph_irq_o == '0))
    else $error("reset outputs wrong");

  // Remaining direct transitions
  hs_to_sub_a: assert property ( // RULE_03
    (mode == sleep_mode_pkg::MODE_HIGH_SPEED && sleep_pulse && dt && sby && tmr && ls)
      |=> mode == sleep_mode_pkg::MODE_SUBACTIVE)
    else $error("high to subactive direct failed");
  ms_to_hs_a: assert property ( // RULE_04
    (mode == sleep_mode_pkg::MODE_MEDIUM_SPEED && sleep_pulse && dt && !sby && !ms && !ls)
      |=> mode == sleep_mode_pkg::MODE_HIGH_SPEED)
    else $error("medium to high direct failed");
  sub_to_ms_a: assert property ( // RULE_05
    (mode == sleep_mode_pkg::MODE_SUBACTIVE && sleep_pulse && dt && sby && tmr && !ls && ms)
      |=> mode == sleep_mode_pkg::MODE_MEDIUM_SPEED)
    else $error("subactive to medium direct failed");
  direct_hold_a: assert property ( // RULE_05
    (mode == sleep_mode_pkg::MODE_SUBACTIVE && sleep_pulse && dt && !(sby && tmr && !ls))
      |=> mode == sleep_mode_pkg::MODE_SUBACTIVE)
    else $error("unmatched direct combination moved");

  // Medium speed entry to low power and the wake targets
  med_to_lp_a: assert property ( // RULE_01
    (mode == sleep_mode_pkg::MODE_MEDIUM_SPEED && sleep_pulse && !dt)
      |=> (mode inside {sleep_mode_pkg::MODE_SLEEP, sleep_mode_pkg::MODE_WATCH,
                        sleep_mode_pkg::MODE_STANDBY}))
    else $error("medium sleep did not enter low power");
  wake_high_a: assert property ( // RULE_06
    (mode inside {sleep_mode_pkg::MODE_SLEEP, sleep_mode_pkg::MODE_WATCH,
                  sleep_mode_pkg::MODE_STANDBY} && wake_sync[1] && !ms)
      |=> mode == sleep_mode_pkg::MODE_HIGH_SPEED)
    else $error("wake to high speed wrong");
  wake_medium_a: assert property ( // RULE_06
    (mode inside {sleep_mode_pkg::MODE_SLEEP, sleep_mode_pkg::MODE_WATCH} && wake_sync[1] && ms)
      |=> mode == sleep_mode_pkg::MODE_MEDIUM_SPEED)
    else $error("wake to medium speed wrong");
  subsleep_wake_a: assert property ( // RULE_02
    (mode == sleep_mode_pkg::MODE_SUBSLEEP && wake_sync[1])
      |=> mode == sleep_mode_pkg::MODE_SUBACTIVE)
    else $error("subsleep wake wrong");

  // Module standby outputs
  stop_follow_a: assert property ( // RULE_07
    mstby[0] |=> periph_stop_o[0])
    else $error("stop output missing");
  irq_follow_a: assert property ( // RULE_07
    !mstby[0] |=> (periph_irq_o[0] == $past(irq_sync[0])))
    else $error("running request not passed on");

  // Main scenarios reached
  cov_sub_c: cover property (mode == sleep_mode_pkg::MODE_SUBACTIVE);
  cov_watch_c: cover property (mode == sleep_mode_pkg::MODE_WATCH ##[1:50] wake_sync[1]);
  cov_hold_c: cover property (mstby[0] && periph_irq_o[0]);
  cov_subsleep_c: cover property (mode == sleep_mode_pkg::MODE_SUBSLEEP);
  cov_medium_c: cover property (mode == sleep_mode_pkg::MODE_MEDIUM_SPEED);

endmodule

//--- sleep_mode_transition_control_tb.sv
// Self-checking bench for the sleep mode sequencer
`timescale 1ns/1ps
module sleep_mode_transition_control_tb;
  logic clk_i = 1'b0, rst_b_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
  logic sleep_exec_i = 1'b0, wake_event_i = 1'b0;
  logic [3:0] address_i = 4'h0;
  logic [31:0] writedata_i = 32'h0, readdata_o, q;
  logic waitrequest_o;
  logic [7:0] periph_irq_i = 8'h00, periph_irq_o, periph_stop_o;
  logic [6:0] mode_o;
  int errors = 0, check_count = 0, cyc = 0;
  sleep_mode_transition_control dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .sleep_exec_i(sleep_exec_i), .wake_event_i(wake_event_i),
    .periph_irq_i(periph_irq_i), .mode_o(mode_o), .periph_irq_o(periph_irq_o),
    .periph_stop_o(periph_stop_o));
  // Clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    read_i <= !w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  // Set control bits, pulse the sleep pin, compare the mode
  task automatic go(input logic [4:0] c, input sleep_mode_pkg::mode_t m, input string s);
    bus(1'b1, 4'h0, {27'h0, c});
    sleep_exec_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sleep_exec_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({25'h0, mode_o}, {25'h0, m}, s);
  endtask
  task automatic wk(input sleep_mode_pkg::mode_t m);
    @(posedge clk_i);
    wake_event_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wake_event_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({25'h0, mode_o}, {25'h0, m}, "wake");
  endtask
  task automatic t_reset();
    chk({25'h0, mode_o}, 32'h01, "reset mode");
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0, "reset ctrl");
    $display("test reset done");
  endtask
  task automatic t_nondirect();
    go(5'h00, sleep_mode_pkg::MODE_SLEEP, "sleep");
    wk(sleep_mode_pkg::MODE_HIGH_SPEED);
    go(5'h11, sleep_mode_pkg::MODE_WATCH, "watch");
    wk(sleep_mode_pkg::MODE_HIGH_SPEED);
    go(5'h14, sleep_mode_pkg::MODE_STANDBY, "standby");
    wk(sleep_mode_pkg::MODE_MEDIUM_SPEED);
    go(5'h04, sleep_mode_pkg::MODE_SLEEP, "sleep med");
    wk(sleep_mode_pkg::MODE_MEDIUM_SPEED);
    $display("test nondirect done");
  endtask
  task automatic t_direct();
    go(5'h08, sleep_mode_pkg::MODE_HIGH_SPEED, "med to high");
    go(5'h0c, sleep_mode_pkg::MODE_MEDIUM_SPEED, "high to med");
    go(5'h1b, sleep_mode_pkg::MODE_SUBACTIVE, "med to sub");
    go(5'h19, sleep_mode_pkg::MODE_HIGH_SPEED, "sub to high");
    go(5'h1b, sleep_mode_pkg::MODE_SUBACTIVE, "high to sub");
    go(5'h1d, sleep_mode_pkg::MODE_MEDIUM_SPEED, "sub to med");
    go(5'h1b, sleep_mode_pkg::MODE_SUBACTIVE, "med to sub 2");
    go(5'h18, sleep_mode_pkg::MODE_SUBACTIVE, "no match");
    go(5'h00, sleep_mode_pkg::MODE_SUBSLEEP, "subsleep");
    wk(sleep_mode_pkg::MODE_SUBACTIVE);
    go(5'h11, sleep_mode_pkg::MODE_WATCH, "sub watch");
    wk(sleep_mode_pkg::MODE_HIGH_SPEED);
    $display("test direct done");
  endtask
  task automatic t_mstby();
    periph_irq_i <= 8'h05;
    repeat (5) @(posedge clk_i);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h05, "irq read");
    bus(1'b1, 4'h8, 32'h01);
    periph_irq_i <= 8'h00;
    repeat (5) @(posedge clk_i);
    chk({24'h0, periph_irq_o}, 32'h01, "frozen irq");
    chk({24'h0, periph_stop_o}, 32'h01, "stop");
    bus(1'b1, 4'h8, 32'h03);
    periph_irq_i <= 8'h02;
    repeat (5) @(posedge clk_i);
    chk({24'h0, periph_irq_o}, 32'h01, "late request held off");
    chk({24'h0, periph_stop_o}, 32'h03, "stop two");
    $display("test module standby done");
  endtask
  task automatic t_bus();
    bus(1'b1, 4'h4, 32'h7f);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h01, "mode ro");
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, 4'h0, 32'h1f);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1f, "ctrl rw");
    $display("test bus done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_nondirect();
    t_direct();
    t_mstby();
    t_bus();
    tally_and_finish();
  end
endmodule
